// file: timer_clock_level_pkg.sv
// Constants shared by the timer clock-source and output-level control slice.
// Assumes one 100 MHz core clock and a 32-bit Avalon-MM register bus.
`default_nettype none

package timer_clock_level_pkg;

    // ----------------------------------------------------------------
    // Bus and register map
    // ----------------------------------------------------------------
    localparam int          BUS_ADDR_W     = 4;
    localparam int          BUS_DATA_W     = 32;
    localparam logic [3:0]  CONTROL_OFFSET = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET  = 4'h4;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int          CTRL_W          = 8;
    localparam int          COUNTER_CLEAR_ENABLE_BIT        = 7;
    localparam int          CKS_LSB         = 4;
    localparam int          CKS_W           = 3;
    localparam int          LEVEL_LSB       = 1;
    localparam int          PIN_COUNT       = 3;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  CTRL_WRITE_MASK = 8'hfe;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int          STAT_LEVEL_LSB  = 1;
    localparam int          STAT_SEEN_LSB   = 4;
    localparam int          STAT_COUNT_LSB  = 16;
    localparam int          COUNT_W         = 16;

    // ----------------------------------------------------------------
    // Clock source codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  CKS_DIV1  = 3'h0;
    localparam logic [2:0]  CKS_DIV2  = 3'h1;
    localparam logic [2:0]  CKS_DIV4  = 3'h2;
    localparam logic [2:0]  CKS_DIV8  = 3'h3;
    localparam int          CKS_EXT_BIT = 2;
    localparam int          DIV_W       = 3;
    localparam logic [2:0]  DIV_LAST    = 3'h7;

    // Bus handshake states.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

endpackage

`default_nettype wire

// file: count_source_gen.sv
// Count-enable generator: prescale taps, external event edges, subclock edges.
// Assumes raw pin inputs are asynchronous to core_clk and sub_mode is on core_clk.
`timescale 1ns/1ps
`default_nettype none

module count_source_gen (
    input  wire logic                                   core_clk,
    input  wire logic                                   rst,
    input  wire logic [timer_clock_level_pkg::CKS_W-1:0] select,
    input  wire logic                                   sub_mode,
    input  wire logic                                   event_pin,
    input  wire logic                                   subclock_pin,
    output logic                                        count_tick
);
    import timer_clock_level_pkg::*;

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] next_div_q;
    logic [2:0]       ev_sh;
    logic [2:0]       next_ev_sh;
    logic [2:0]       sub_sh;
    logic [2:0]       next_sub_sh;
    logic             next_count_tick;
    logic             ev_edge;
    logic             sub_edge;

    // The divider runs free, so a tap change takes effect on the next cycle, without restarting the divider phase.
    function automatic logic tap_hit(input logic [DIV_W-1:0] q, input logic [2:0] sel);
        logic hit;
        hit = 1'b0;
        unique case (sel[1:0])
            CKS_DIV1[1:0]: hit = 1'b1;
            CKS_DIV2[1:0]: hit = q[0];
            CKS_DIV4[1:0]: hit = &q[1:0];
            CKS_DIV8[1:0]: hit = (q == DIV_LAST);
        endcase
        return hit;
    endfunction

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    always_comb begin
        next_div_q  = div_q + 3'h1;
        next_ev_sh  = {ev_sh[1:0], event_pin};
        next_sub_sh = {sub_sh[1:0], subclock_pin};
        ev_edge     = ev_sh[1] & ~ev_sh[2];
        sub_edge    = sub_sh[1] & ~sub_sh[2];
        if (select[CKS_EXT_BIT]) begin
            next_count_tick = ev_edge;
        end else if (sub_mode) begin
            next_count_tick = sub_edge;
        end else begin
            next_count_tick = tap_hit(div_q, select);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q      <= 3'h0;
            ev_sh      <= 3'h0;
            sub_sh     <= 3'h0;
            count_tick <= 1'b0;
        end else begin
            div_q      <= next_div_q;
            ev_sh      <= next_ev_sh;
            sub_sh     <= next_sub_sh;
            count_tick <= next_count_tick;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_div1_every_cycle: assert property (@(posedge core_clk) disable iff (rst)
        (select == CKS_DIV1 && !sub_mode) |=> (count_tick || $past(select) != CKS_DIV1 || $past(sub_mode)))
        else $error("undivided source missed a cycle");
    a_div2_gap: assert property (@(posedge core_clk) disable iff (rst)
        (count_tick && $past(select) == CKS_DIV2 && !$past(sub_mode) && select == CKS_DIV2 && !sub_mode)
        |=> (!count_tick || $past(select) != CKS_DIV2 || $past(sub_mode)))
        else $error("divide by two ticked twice in a row");
    a_div8_phase: assert property (@(posedge core_clk) disable iff (rst)
        (select == CKS_DIV8 && !sub_mode) |=> (count_tick == ($past(div_q) == DIV_LAST) || $past(select) != CKS_DIV8
        || $past(sub_mode)))
        else $error("divide by eight tick out of phase");
    a_ext_edge_tick: assert property (@(posedge core_clk) disable iff (rst)
        (select[CKS_EXT_BIT] && ev_sh[1] && !ev_sh[2]) |=> (count_tick || !$past(select[CKS_EXT_BIT])))
        else $error("event edge not counted");
    a_ext_no_level: assert property (@(posedge core_clk) disable iff (rst)
        (select[CKS_EXT_BIT] && ev_sh[2]) |=> !count_tick || !$past(select[CKS_EXT_BIT]))
        else $error("event level counted twice");
    a_sub_edge_only: assert property (@(posedge core_clk) disable iff (rst)
        (!select[CKS_EXT_BIT] && sub_mode && !(sub_sh[1] && !sub_sh[2])) |=> !count_tick)
        else $error("sub mode ticked without subclock edge");

    c_ext_tick: cover property (@(posedge core_clk) disable iff (rst) select[CKS_EXT_BIT] && count_tick);
    c_sub_tick: cover property (@(posedge core_clk) disable iff (rst) !select[CKS_EXT_BIT] && sub_mode && count_tick);

endmodule

`default_nettype wire

// file: timer_clock_and_output_level_ctl.sv
// Timer channel slice: count clock selection, counter, and initial compare output levels.
// Assumes compare match pulses come from neighbouring logic on core_clk, one cycle each.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Select field codes 000..011 count the system clock undivided, /2, /4, /8.
// - Select field top bit set counts rising edges of the external event input.
// - Internal source in subactive or subsleep mode counts the subclock instead.
// - Pin D shows control bit 3 from configuration until first compare match D.
// - Pin C shows control bit 2 until the first compare match C.
// - Pin B shows control bit 1 until the first compare match B.
// - With counter clear enable at 0 the counter runs freely, never cleared.
module timer_clock_and_output_level_ctl (
    input  wire logic                                          core_clk,
    input  wire logic                                          rst,
    input  wire logic [timer_clock_level_pkg::BUS_ADDR_W-1:0]  avs_address,
    input  wire logic                                          avs_read,
    input  wire logic                                          avs_write,
    input  wire logic [timer_clock_level_pkg::BUS_DATA_W-1:0]  avs_writedata,
    input  wire logic [3:0]                                    avs_byteenable,
    output logic      [timer_clock_level_pkg::BUS_DATA_W-1:0]  avs_readdata,
    output logic                                               avs_waitrequest,
    input  wire logic                                          external_event_count_input,
    input  wire logic                                          subclock_input,
    input  wire logic                                          sub_power_mode,
    input  wire logic                                          compare_match_a,
    input  wire logic                                          compare_match_b,
    input  wire logic                                          compare_match_c,
    input  wire logic                                          compare_match_d,
    output logic                                               compare_output_pin_b,
    output logic                                               compare_output_pin_c,
    output logic                                               compare_output_pin_d,
    output logic                                               count_enable,
    output logic                                               counter_clear_enable,
    output logic      [timer_clock_level_pkg::COUNT_W-1:0]     timer_count_value
);
    import timer_clock_level_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    bus_state_t              bus_state;
    bus_state_t              next_bus_state;
    logic [CTRL_W-1:0]       control;
    logic [CTRL_W-1:0]       next_control;
    logic [PIN_COUNT-1:0]    seen;
    logic [PIN_COUNT-1:0]    next_seen;
    logic [PIN_COUNT-1:0]    pin_level;
    logic [PIN_COUNT-1:0]    next_pin_level;
    logic [PIN_COUNT-1:0]    match;
    logic [PIN_COUNT-1:0]    init_level;
    logic [PIN_COUNT-1:0]    seen_kept;
    logic [COUNT_W-1:0]      count;
    logic [COUNT_W-1:0]      next_count;
    logic [BUS_DATA_W-1:0]   readdata_q;
    logic [BUS_DATA_W-1:0]   next_readdata;
    logic                    access;
    logic                    accept;
    logic                    control_write;
    logic                    count_tick;
    logic [CKS_W-1:0]        clock_select;

    function automatic logic [BUS_DATA_W-1:0] read_word(
        input logic [BUS_ADDR_W-1:0] addr,
        input logic [CTRL_W-1:0]     ctl,
        input logic [PIN_COUNT-1:0]  lvl,
        input logic [PIN_COUNT-1:0]  sn,
        input logic [COUNT_W-1:0]    cnt
    );
        logic [BUS_DATA_W-1:0] word;
        word = '0;
        if (addr == CONTROL_OFFSET) begin
            word[CTRL_W-1:0] = ctl;
        end else if (addr == STATUS_OFFSET) begin
            word[STAT_LEVEL_LSB +: PIN_COUNT] = lvl;
            word[STAT_SEEN_LSB +: PIN_COUNT]  = sn;
            word[STAT_COUNT_LSB +: COUNT_W]   = cnt;
        end
        return word;
    endfunction

    assign match        = {compare_match_d, compare_match_c, compare_match_b};
    assign clock_select = control[CKS_LSB +: CKS_W];

    // ----------------------------------------------------------------
    // Count source
    // ----------------------------------------------------------------
    count_source_gen u_source (
        .core_clk     (core_clk),
        .rst          (rst),
        .select       (clock_select),
        .sub_mode     (sub_power_mode),
        .event_pin    (external_event_count_input),
        .subclock_pin (subclock_input),
        .count_tick   (count_tick)
    );

    // ----------------------------------------------------------------
    // Avalon slave: one wait cycle, then the answer
    // ----------------------------------------------------------------
    // A fixed single wait state keeps read data registered without a combinational mux on the bus.
    assign access          = avs_read || avs_write;
    assign accept          = access && (bus_state == BUS_ACK);
    assign avs_waitrequest = access && (bus_state != BUS_ACK);
    assign avs_readdata    = readdata_q;
    assign control_write   = accept && avs_write && (avs_address == CONTROL_OFFSET) && avs_byteenable[0];

    always_comb begin
        next_bus_state = BUS_IDLE;
        next_readdata  = readdata_q;
        unique case (bus_state)
            BUS_IDLE: begin
                if (access) begin
                    next_bus_state = BUS_ACK;
                    next_readdata  = read_word(avs_address, control, pin_level, seen, count);
                end
            end
            BUS_ACK: begin
                next_bus_state = BUS_IDLE;
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_state  <= BUS_IDLE;
            readdata_q <= '0;
        end else begin
            bus_state  <= next_bus_state;
            readdata_q <= next_readdata;
        end
    end

    // ----------------------------------------------------------------
    // Control register and compare output levels
    // ----------------------------------------------------------------
    // After the first match each pin toggles on its match; a new control write re-arms the initial level.
    always_comb begin
        next_control = control;
        if (control_write) begin
            next_control = avs_writedata[CTRL_W-1:0] & CTRL_WRITE_MASK;
        end
        init_level     = next_control[LEVEL_LSB +: PIN_COUNT];
        seen_kept      = control_write ? '0 : seen;
        next_seen      = seen_kept | match;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (match[i]) begin
                next_pin_level[i] = ~pin_level[i];
            end else if (seen_kept[i]) begin
                next_pin_level[i] = pin_level[i];
            end else begin
                next_pin_level[i] = init_level[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control   <= CTRL_RESET;
            seen      <= '0;
            pin_level <= '0;
        end else begin
            control   <= next_control;
            seen      <= next_seen;
            pin_level <= next_pin_level;
        end
    end

    assign compare_output_pin_b = pin_level[0];
    assign compare_output_pin_c = pin_level[1];
    assign compare_output_pin_d = pin_level[2];
    assign counter_clear_enable = control[COUNTER_CLEAR_ENABLE_BIT];
    assign count_enable         = count_tick;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_comb begin
        next_count = count;
        if (counter_clear_enable && compare_match_a) begin
            next_count = '0;
        end else if (count_tick) begin
            next_count = count + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign timer_count_value = count;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_pin_d_init: assert property (@(posedge core_clk) disable iff (rst)
        (control_write && !compare_match_d) |=> compare_output_pin_d == $past(avs_writedata[3]))
        else $error("pin d does not show its initial level");
    a_pin_c_init: assert property (@(posedge core_clk) disable iff (rst)
        (control_write && !compare_match_c) |=> compare_output_pin_c == $past(avs_writedata[2]))
        else $error("pin c does not show its initial level");
    a_pin_b_hold: assert property (@(posedge core_clk) disable iff (rst)
        (control_write && !compare_match_b) ##1 (!compare_match_b)[*3] |=> compare_output_pin_b == control[1])
        else $error("pin b left its initial level before a match");
    a_match_moves_pin: assert property (@(posedge core_clk) disable iff (rst)
        compare_match_b |=> compare_output_pin_b != $past(compare_output_pin_b))
        else $error("compare match b did not move the pin");
    a_free_run: assert property (@(posedge core_clk) disable iff (rst)
        (!counter_clear_enable && count_enable) |=> timer_count_value == $past(timer_count_value) + 16'h0001)
        else $error("free running counter failed to advance");
    a_no_clear_free: assert property (@(posedge core_clk) disable iff (rst)
        (!counter_clear_enable && compare_match_a && !count_enable) |=> $stable(timer_count_value))
        else $error("counter cleared while clearing is off");
    a_bus_one_wait: assert property (@(posedge core_clk) disable iff (rst)
        (access && avs_waitrequest) |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");

    c_first_match_d: cover property (@(posedge core_clk) disable iff (rst) compare_match_d && !seen[2]);
    c_clear_on_match: cover property (@(posedge core_clk) disable iff (rst) counter_clear_enable && compare_match_a);
    c_status_read: cover property (@(posedge core_clk) disable iff (rst)
        accept && avs_read && avs_address == STATUS_OFFSET);

endmodule

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the timer clock-source and initial output-level slice.
// Assumes the package and design files are compiled first; one 100 MHz clock, no partner model.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import timer_clock_level_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic                  core_clk      = 1'b0;
    logic                  rst           = 1'b1;
    logic [BUS_ADDR_W-1:0] avs_address   = '0;
    logic                  avs_read      = 1'b0;
    logic                  avs_write     = 1'b0;
    logic [BUS_DATA_W-1:0] avs_writedata = '0;
    logic [3:0]            avs_byteenable = 4'h0;
    logic [BUS_DATA_W-1:0] avs_readdata;
    logic                  avs_waitrequest;
    logic                  event_in      = 1'b0;
    logic                  subclock_in   = 1'b0;
    logic                  sub_mode      = 1'b0;
    logic [3:0]            match_vec     = 4'h0;
    logic                  pin_b;
    logic                  pin_c;
    logic                  pin_d;
    logic                  count_enable;
    logic                  clear_en;
    logic [COUNT_W-1:0]    count_value;
    logic [BUS_DATA_W-1:0] rd;
    logic [COUNT_W-1:0]    v0;
    int                    err_count     = 0;
    int                    num_checks    = 0;
    int                    pulse_cnt     = 0;
    int                    n;

    timer_clock_and_output_level_ctl dut_u (
        .core_clk                   (core_clk),
        .rst                        (rst),
        .avs_address                (avs_address),
        .avs_read                   (avs_read),
        .avs_write                  (avs_write),
        .avs_writedata              (avs_writedata),
        .avs_byteenable             (avs_byteenable),
        .avs_readdata               (avs_readdata),
        .avs_waitrequest            (avs_waitrequest),
        .external_event_count_input (event_in),
        .subclock_input             (subclock_in),
        .sub_power_mode             (sub_mode),
        .compare_match_a            (match_vec[0]),
        .compare_match_b            (match_vec[1]),
        .compare_match_c            (match_vec[2]),
        .compare_match_d            (match_vec[3]),
        .compare_output_pin_b       (pin_b),
        .compare_output_pin_c       (pin_c),
        .compare_output_pin_d       (pin_d),
        .count_enable               (count_enable),
        .counter_clear_enable       (clear_en),
        .timer_count_value          (count_value)
    );

    // ----------------------------------------------------------------
    // Clock, pulse counter and helper tasks
    // ----------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (count_enable === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waitrequest is read just after the rising edge, before that edge's register updates land.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] data);
        int k;
        @(posedge core_clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            print_verdict();
        end
        data = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic pins_are(input logic [2:0] exp);
        @(negedge core_clk);
        check(32'({pin_d, pin_c, pin_b}), 32'(exp));
    endtask

    task automatic hit(input int i);
        @(posedge core_clk);
        match_vec[i] <= 1'b1;
        @(posedge core_clk);
        match_vec[i] <= 1'b0;
    endtask

    task automatic measure(input int cycles, output int cnt);
        int s;
        @(negedge core_clk);
        s = pulse_cnt;
        repeat (cycles) @(negedge core_clk);
        cnt = pulse_cnt - s;
    endtask

    // Slow edges with a tail long enough to cover the synchroniser latency.
    task automatic edges(input bit sub, input int k, output int cnt);
        int s;
        @(negedge core_clk);
        s = pulse_cnt;
        repeat (k) begin
            @(posedge core_clk);
            if (sub) subclock_in <= 1'b1;
            else event_in <= 1'b1;
            repeat (4) @(posedge core_clk);
            if (sub) subclock_in <= 1'b0;
            else event_in <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        repeat (8) @(negedge core_clk);
        cnt = pulse_cnt - s;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        pins_are(3'b000);
        bus(1'b0, CONTROL_OFFSET, 32'h0, 4'hf, rd);
        check(rd, 32'(CTRL_RESET));
        bus(1'b1, CONTROL_OFFSET, 32'h0000_000b, 4'hf, rd);
        bus(1'b0, CONTROL_OFFSET, 32'h0, 4'hf, rd);
        check(rd, 32'h0000_000a);
        pins_are(3'b101);
        hit(1);
        pins_are(3'b100);
        bus(1'b1, CONTROL_OFFSET, 32'h0000_0004, 4'hf, rd);
        pins_are(3'b010);
        hit(2);
        pins_are(3'b000);
        hit(3);
        pins_are(3'b100);
        bus(1'b1, CONTROL_OFFSET, 32'h0000_000e, 4'he, rd);
        pins_are(3'b100);
        bus(1'b1, CONTROL_OFFSET, 32'h0000_000e, 4'hf, rd);
        pins_are(3'b111);
        bus(1'b0, STATUS_OFFSET, 32'h0, 4'hf, rd);
        check(rd & 32'h0000_007e, 32'h0000_000e);
        bus(1'b1, 4'h8, 32'h0000_00ff, 4'hf, rd);
        bus(1'b0, 4'h8, 32'h0, 4'hf, rd);
        check(rd, 32'h0);
        bus(1'b0, CONTROL_OFFSET, 32'h0, 4'hf, rd);
        check(rd, 32'h0000_000e);
        // Window of 64 is a multiple of every divide ratio, so phase does not matter.
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, CONTROL_OFFSET, 32'(i) << CKS_LSB, 4'hf, rd);
            repeat (3) @(posedge core_clk);
            measure(64, n);
            check(32'(n), 32'(64 >> i));
        end
        // Divide by eight here, so the ignored match usually lands in a cycle without a count.
        bus(1'b1, CONTROL_OFFSET, 32'h0000_0030, 4'hf, rd);
        @(negedge core_clk);
        check(32'(clear_en), 32'h0);
        repeat (4) @(negedge core_clk);
        v0 = count_value;
        hit(0);
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        check(32'(count_value), 32'(v0 + 16'h0001));
        bus(1'b1, CONTROL_OFFSET, 32'h0000_0080, 4'hf, rd);
        @(negedge core_clk);
        check(32'(clear_en), 32'h1);
        hit(0);
        @(negedge core_clk);
        check(32'(count_value), 32'h0);
        repeat (3) @(negedge core_clk);
        check(32'(count_value), 32'h3);
        @(posedge core_clk);
        sub_mode <= 1'b1;
        bus(1'b1, CONTROL_OFFSET, 32'h0, 4'hf, rd);
        edges(1'b1, 5, n);
        check(32'(n), 32'h5);
        bus(1'b1, CONTROL_OFFSET, 32'h0000_0010, 4'hf, rd);
        edges(1'b1, 3, n);
        check(32'(n), 32'h3);
        measure(32, n);
        check(32'(n), 32'h0);
        bus(1'b1, CONTROL_OFFSET, 32'h0000_0070, 4'hf, rd);
        edges(1'b0, 5, n);
        check(32'(n), 32'h5);
        edges(1'b1, 3, n);
        check(32'(n), 32'h0);
        @(posedge core_clk);
        sub_mode <= 1'b0;
        bus(1'b1, CONTROL_OFFSET, 32'h0000_0040, 4'hf, rd);
        edges(1'b0, 4, n);
        check(32'(n), 32'h4);
        measure(32, n);
        check(32'(n), 32'h0);
        print_verdict();
    end

endmodule

`default_nettype wire
